// File: hdl/ltc_pkg.sv
// ==========================================================================
// Local timing control constants
package ltc_pkg;

  // Register bus geometry
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_FGA_MODE  = 8'h04;
  localparam logic [7:0]  OFS_FGA_LEVEL = 8'h08;
  localparam logic [7:0]  OFS_FGB_MODE  = 8'h0C;
  localparam logic [7:0]  OFS_FGB_LEVEL = 8'h10;
  localparam logic [7:0]  OFS_FG_POS    = 8'h14;
  localparam logic [7:0]  OFS_STATUS    = 8'h18;

  // Control register fields
  localparam int          CTRL_MASTER   = 0;
  localparam int          CTRL_SEC_DRV  = 1;
  localparam int          CTRL_C2_DRV   = 2;
  localparam int          CTRL_RATE_LSB = 3;
  localparam int          CTRL_POL8     = 5;
  localparam int          CTRL_POL4     = 6;
  localparam int          CTRL_POL2     = 7;
  localparam int          CTRL_W        = 8;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  // Frame position register fields
  localparam int          POS_W         = 9;
  localparam int          POS_B_LSB     = 16;
  localparam logic [8:0]  POS_RST       = 9'h1FF;

  // Status register fields
  localparam int          STAT_FRAME    = 16;
  localparam int          STAT_LOCAL_CLOCK_4M     = 17;
  localparam int          STAT_SECONDARY_8K_REFERENCE    = 18;
  localparam int          STAT_MASTER   = 19;

  // Frame group geometry
  localparam int          FG_COUNT      = 12;
  localparam logic [23:0] FG_MODE_RST   = 24'h00_0000;
  localparam logic [11:0] FG_LEVEL_RST  = 12'hFFF;

  // Frame timebase: one frame is 2048 core cycles
  localparam int          FRAME_CNT_W   = 11;
  localparam int          SLOT_W        = 7;
  localparam int          CTL_SLOT_LSB  = 4;
  localparam logic [3:0]  CTL_PHASE0    = 4'h0;
  localparam logic [8:0]  FRAME_LOW_POS = 9'h1FF;
  localparam logic [10:0] SLAVE_ALIGN   = 11'h7FE;

  // Frame group output modes
  typedef enum logic [1:0] {
    FG_STATIC = 2'b00,
    FG_DRIVE  = 2'b01,
    FG_PULSE  = 2'b10,
    FG_RSVD   = 2'b11
  } ltc_fg_mode_t;

  // Local serial rates
  typedef enum logic [1:0] {
    RATE_2M = 2'b00,
    RATE_4M = 2'b01,
    RATE_8M = 2'b10,
    RATE_XX = 2'b11
  } ltc_rate_t;

  // Bit period masks on the frame counter per rate
  localparam logic [10:0] MASK_2M       = 11'h007;
  localparam logic [10:0] MASK_4M       = 11'h003;
  localparam logic [10:0] MASK_8M       = 11'h001;

endpackage : ltc_pkg

// File: hdl/ltc_tick_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Control stream timing carrier
interface ltc_tick_if;
  logic                         ctl_tick;
  logic [ltc_pkg::SLOT_W-1:0]   ctl_slot;
  logic                         ctl_bit;
  modport src (output ctl_tick, output ctl_slot, input ctl_bit);
  modport ser (input ctl_tick, input ctl_slot, output ctl_bit);
endinterface : ltc_tick_if

// File: hdl/ltc_cstream.sv
`timescale 1ns/1ps
// ==========================================================================
// Control stream serializer
module ltc_cstream
  import ltc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Timing from the frame counter
  ltc_tick_if.ser                tk,
  // Connection memory control bit lookup
  output logic [SLOT_W-1:0]      cm_addr,
  input  wire logic              cm_bit
);

  logic [SLOT_W-1:0] addr_reg;
  logic              bit_reg;
  wire  [SLOT_W-1:0] addr_next = SLOT_W'(tk.ctl_slot + 1'b1);
  wire               bit_next  = tk.ctl_tick ? cm_bit : bit_reg;

  // Prefetch next slot address, launch bit on slot start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      bit_reg  <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      bit_reg  <= bit_next; // R3
    end
  end

  assign cm_addr    = addr_reg;
  assign tk.ctl_bit = bit_reg;

  // ========================================================================
  // Checks
  chk_cs_bit: assert property (@(posedge clk) disable iff (rst) // R3
    tk.ctl_tick |=> (tk.ctl_bit == $past(cm_bit)))
    else $error("control stream bit not taken from memory");

  chk_cs_hold: assert property (@(posedge clk) disable iff (rst) // R3
    !tk.ctl_tick |=> $stable(tk.ctl_bit))
    else $error("control stream bit changed inside slot");

  cov_cs_one: cover property (@(posedge clk) disable iff (rst)
    tk.ctl_tick && cm_bit ##1 tk.ctl_bit);

endmodule : ltc_cstream

// File: hdl/ltc_top.sv
`timescale 1ns/1ps
// ==========================================================================
// Summary of operation
// R1: Local streams run at 2, 4 or 8 Mb/s
// R2: Control stream has a fixed bit rate
// R3: Control bits come from connection memory
// R4: Backplane 2 MHz clock floats unless selected
// R5: Local frame matches backplane frame exactly as master; as slave it lags the received frame by 2 cycles
// R6: Free-running 8 MHz local clock
// R7: Local 4 MHz clock equals backplane 4 MHz; as slave it lags the received 4 MHz clock by 2 cycles
// R8: Local 2 MHz clock equals backplane 2 MHz
// R9: Local clock polarities are programmable
// R10: Two independent groups of framing outputs
// R11: Group A: level, stream drive, or pulse
// R12: Group B: level, stream drive, or pulse
// R13: Secondary 8k line is input or output
// R14: 4 MHz line driven as master, received otherwise
// R15: Frame line driven or received per mode
// R16: Reset clears the control and mode registers, and sets levels and positions to all ones
// R17: Group pulses share the frame counter
module ltc_top
  import ltc_pkg::*;
#(
  parameter int FG_WIDTH = FG_COUNT
) (
  // Clock and reset
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  // Register port
  input  wire logic [ADDR_W-1:0]   REG_ADDR,
  input  wire logic [DATA_W-1:0]   REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic      [DATA_W-1:0]   REG_RDATA,
  // Backplane frame line
  input  wire logic                BACKPLANE_FRAME_PULSE_N_I,
  output logic                     BACKPLANE_FRAME_PULSE_N_O,
  output logic                     BACKPLANE_FRAME_PULSE_N_OE,
  // Backplane clock lines
  input  wire logic                BACKPLANE_CLOCK_4M_I,
  output logic                     BACKPLANE_CLOCK_4M_O,
  output logic                     BACKPLANE_CLOCK_4M_OE,
  output logic                     BACKPLANE_CLOCK_2M_O,
  output logic                     BACKPLANE_CLOCK_2M_OE,
  // Secondary 8k line
  input  wire logic                SECONDARY_8K_REFERENCE_I,
  output logic                     SECONDARY_8K_REFERENCE_O,
  output logic                     SECONDARY_8K_REFERENCE_OE,
  output logic                     DPLL_REF_PULSE,
  // Local clocks and frame
  output logic                     LOCAL_CLOCK_8M,
  output logic                     LOCAL_CLOCK_4M,
  output logic                     LOCAL_CLOCK_2M,
  output logic                     LOCAL_FRAME_N,
  // Local serial streams
  output logic      [3:0]          LOCAL_SERIAL_OUT,
  input  wire logic [3:0]          LOCAL_SERIAL_IN,
  input  wire logic [3:0]          LOCAL_TX_BITS,
  output logic      [3:0]          LOCAL_RX_BITS,
  output logic                     LOCAL_BIT_STROBE,
  // Control stream
  output logic                     CONTROL_STREAM_OUT,
  output logic      [SLOT_W-1:0]   CM_SLOT_ADDR,
  input  wire logic                CM_CTRL_BIT,
  // Frame groups
  input  wire logic [FG_WIDTH-1:0] STREAM_OUT_DRIVE_EN,
  input  wire logic [FG_WIDTH-1:0] STREAM_IN_DRIVE_EN,
  output logic      [FG_WIDTH-1:0] FRAME_GROUP_A_OUT,
  output logic      [FG_WIDTH-1:0] FRAME_GROUP_B_OUT
);

  // Refuse group widths the register layout cannot hold
  if (FG_WIDTH < 1 || FG_WIDTH > FG_COUNT) begin : g_bad_width
    $error("FG_WIDTH out of range");
  end

  // ========================================================================
  // Register file
  logic [CTRL_W-1:0]     ctrl_reg;
  logic [2*FG_COUNT-1:0] fga_mode_reg;
  logic [2*FG_COUNT-1:0] fgb_mode_reg;
  logic [FG_COUNT-1:0]   fga_level_reg;
  logic [FG_COUNT-1:0]   fgb_level_reg;
  logic [POS_W-1:0]      fga_pos_reg;
  logic [POS_W-1:0]      fgb_pos_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [DATA_W-1:0]     rdata_next;

  // Write decode
  wire wr_ctrl  = REG_WR && (REG_ADDR == OFS_CTRL);
  wire wr_fgam  = REG_WR && (REG_ADDR == OFS_FGA_MODE);
  wire wr_fgal  = REG_WR && (REG_ADDR == OFS_FGA_LEVEL);
  wire wr_fgbm  = REG_WR && (REG_ADDR == OFS_FGB_MODE);
  wire wr_fgbl  = REG_WR && (REG_ADDR == OFS_FGB_LEVEL);
  wire wr_pos   = REG_WR && (REG_ADDR == OFS_FG_POS);

  // Control fields
  wire       master_reg = ctrl_reg[CTRL_MASTER];
  wire       sec_drv    = ctrl_reg[CTRL_SEC_DRV];
  wire       c2_drv     = ctrl_reg[CTRL_C2_DRV];
  wire       pol8       = ctrl_reg[CTRL_POL8];
  wire       pol4       = ctrl_reg[CTRL_POL4];
  wire       pol2       = ctrl_reg[CTRL_POL2];
  ltc_rate_t rate_sel;
  assign rate_sel = ltc_rate_t'(ctrl_reg[CTRL_RATE_LSB +: 2]);

  // Register writes; reset restores every setting
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg      <= CTRL_RST; // R16
      fga_mode_reg  <= FG_MODE_RST; // R16
      fgb_mode_reg  <= FG_MODE_RST;
      fga_level_reg <= FG_LEVEL_RST;
      fgb_level_reg <= FG_LEVEL_RST;
      fga_pos_reg   <= POS_RST;
      fgb_pos_reg   <= POS_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= REG_WDATA[CTRL_W-1:0]; // R9
      if (wr_fgam) fga_mode_reg <= REG_WDATA[2*FG_COUNT-1:0]; // R10
      if (wr_fgal) fga_level_reg <= REG_WDATA[FG_COUNT-1:0];
      if (wr_fgbm) fgb_mode_reg <= REG_WDATA[2*FG_COUNT-1:0]; // R10
      if (wr_fgbl) fgb_level_reg <= REG_WDATA[FG_COUNT-1:0];
      if (wr_pos) begin
        fga_pos_reg <= REG_WDATA[POS_W-1:0];
        fgb_pos_reg <= REG_WDATA[POS_B_LSB +: POS_W];
      end
    end
  end

  // ========================================================================
  // Pin synchronisers
  logic [1:0] frame_sync;
  logic [1:0] local_clock_4m_sync;
  logic [1:0] sec_sync;
  logic [3:0] ser_sync0;
  logic [3:0] ser_sync1;
  logic       frame_d;
  logic       sec_d;

  // Two flops on each backplane and local serial input, then edge history
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      frame_sync <= 2'h3;
      local_clock_4m_sync  <= 2'h0;
      sec_sync   <= 2'h3; // Idle high, no false edge after reset
      ser_sync0  <= 4'h0;
      ser_sync1  <= 4'h0;
      frame_d    <= 1'b1;
      sec_d      <= 1'b1;
    end else begin
      frame_sync <= {frame_sync[0], BACKPLANE_FRAME_PULSE_N_I};
      local_clock_4m_sync  <= {local_clock_4m_sync[0], BACKPLANE_CLOCK_4M_I};
      sec_sync   <= {sec_sync[0], SECONDARY_8K_REFERENCE_I};
      ser_sync0  <= LOCAL_SERIAL_IN;
      ser_sync1  <= ser_sync0;
      frame_d    <= frame_sync[1];
      sec_d      <= sec_sync[1];
    end
  end

  // Edge detection on synchronised levels
  wire frame_fell = frame_d && !frame_sync[1];
  wire sec_rose   = !sec_d && sec_sync[1];

  // ========================================================================
  // Frame counter
  logic [FRAME_CNT_W-1:0] cnt_reg;
  logic [FRAME_CNT_W-1:0] cnt_next;

  // Slave realigns to the received frame edge, master runs free
  assign cnt_next = (!master_reg && frame_fell) ? SLAVE_ALIGN // R15
                  : FRAME_CNT_W'(cnt_reg + 1'b1);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) cnt_reg <= '0;
    else     cnt_reg <= cnt_next;
  end

  // Timing decode from the shared counter
  wire [8:0] cnt_q4     = cnt_reg[FRAME_CNT_W-1:2];
  wire       frame_low  = (cnt_q4 == FRAME_LOW_POS);
  wire       ctl_tick   = (cnt_reg[CTL_SLOT_LSB-1:0] == CTL_PHASE0); // R2
  wire [10:0] rate_mask = (rate_sel == RATE_4M) ? MASK_4M
                        : (rate_sel == RATE_8M) ? MASK_8M : MASK_2M;
  wire       bit_tick   = ((cnt_reg & rate_mask) == '0); // R1
  wire       pulse_a    = (cnt_q4 == fga_pos_reg); // R17
  wire       pulse_b    = (cnt_q4 == fgb_pos_reg); // R17

  // ========================================================================
  // Clock, frame and direction outputs
  logic local_clock_8m_reg;
  logic local_clock_4m_reg;
  logic local_clock_2m_reg;
  logic bclk4_reg;
  logic bclk2_reg;
  logic frame_n_reg;
  logic drive_reg;
  logic c2_oe_reg;
  logic sec_oe_reg;
  logic ref_reg;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      local_clock_8m_reg    <= 1'b0;
      local_clock_4m_reg    <= 1'b0;
      local_clock_2m_reg    <= 1'b0;
      bclk4_reg   <= 1'b0;
      bclk2_reg   <= 1'b0;
      frame_n_reg <= 1'b1;
      drive_reg   <= 1'b0;
      c2_oe_reg   <= 1'b0;
      sec_oe_reg  <= 1'b0;
      ref_reg     <= 1'b0;
    end else begin
      local_clock_8m_reg    <= cnt_reg[0] ^ pol8; // R6
      local_clock_4m_reg    <= cnt_reg[1] ^ pol4; // R7
      local_clock_2m_reg    <= cnt_reg[2] ^ pol2; // R8
      bclk4_reg   <= cnt_reg[1];
      bclk2_reg   <= cnt_reg[2];
      frame_n_reg <= !frame_low; // R5
      drive_reg   <= master_reg; // R14
      c2_oe_reg   <= c2_drv; // R4
      sec_oe_reg  <= sec_drv; // R13
      ref_reg     <= sec_rose && !sec_drv; // R13
    end
  end

  assign LOCAL_CLOCK_8M             = local_clock_8m_reg;
  assign LOCAL_CLOCK_4M             = local_clock_4m_reg;
  assign LOCAL_CLOCK_2M             = local_clock_2m_reg;
  assign LOCAL_FRAME_N              = frame_n_reg;
  assign BACKPLANE_CLOCK_4M_O       = bclk4_reg;
  assign BACKPLANE_CLOCK_4M_OE      = drive_reg;
  assign BACKPLANE_FRAME_PULSE_N_O  = frame_n_reg;
  assign BACKPLANE_FRAME_PULSE_N_OE = drive_reg;
  assign BACKPLANE_CLOCK_2M_O       = bclk2_reg;
  assign BACKPLANE_CLOCK_2M_OE      = c2_oe_reg;
  assign SECONDARY_8K_REFERENCE_O   = frame_n_reg;
  assign SECONDARY_8K_REFERENCE_OE  = sec_oe_reg;
  assign DPLL_REF_PULSE             = ref_reg;

  // ========================================================================
  // Local serial streams
  logic [3:0] ser_out_reg;
  logic [3:0] ser_in_reg;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ser_out_reg <= 4'h0;
      ser_in_reg  <= 4'h0;
    end else if (bit_tick) begin
      ser_out_reg <= LOCAL_TX_BITS; // R1
      ser_in_reg  <= ser_sync1; // R1
    end
  end

  assign LOCAL_SERIAL_OUT = ser_out_reg;
  assign LOCAL_RX_BITS    = ser_in_reg;
  assign LOCAL_BIT_STROBE = bit_tick;

  // ========================================================================
  // Control stream
  ltc_tick_if tk_if ();
  assign tk_if.ctl_tick = ctl_tick;
  assign tk_if.ctl_slot = cnt_reg[FRAME_CNT_W-1:CTL_SLOT_LSB];

  ltc_cstream u_cstream (
    .clk     (CORE_CLK),
    .rst     (RST),
    .tk      (tk_if),
    .cm_addr (CM_SLOT_ADDR),
    .cm_bit  (CM_CTRL_BIT)
  );

  assign CONTROL_STREAM_OUT = tk_if.ctl_bit; // R2

  // ========================================================================
  // Frame groups
  logic [FG_WIDTH-1:0] fga_next;
  logic [FG_WIDTH-1:0] fgb_next;
  logic [FG_WIDTH-1:0] fga_reg;
  logic [FG_WIDTH-1:0] fgb_reg;

  // Per output function select
  for (genvar i = 0; i < FG_WIDTH; i++) begin : g_fg
    wire [1:0] ma = fga_mode_reg[2*i +: 2];
    wire [1:0] mb = fgb_mode_reg[2*i +: 2];
    assign fga_next[i] = (ma == FG_STATIC) ? fga_level_reg[i] // R11
                       : (ma == FG_DRIVE)  ? STREAM_OUT_DRIVE_EN[i]
                       : (ma == FG_PULSE)  ? !pulse_a : 1'b0;
    assign fgb_next[i] = (mb == FG_STATIC) ? fgb_level_reg[i] // R12
                       : (mb == FG_DRIVE)  ? STREAM_IN_DRIVE_EN[i]
                       : (mb == FG_PULSE)  ? !pulse_b : 1'b0;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fga_reg <= FG_LEVEL_RST[FG_WIDTH-1:0];
      fgb_reg <= FG_LEVEL_RST[FG_WIDTH-1:0];
    end else begin
      fga_reg <= fga_next; // R10
      fgb_reg <= fgb_next; // R10
    end
  end

  assign FRAME_GROUP_A_OUT = fga_reg;
  assign FRAME_GROUP_B_OUT = fgb_reg;

  // ========================================================================
  // Read path
  wire [DATA_W-1:0] status_word = {12'h000, master_reg, sec_sync[1], local_clock_4m_sync[1],
                                   frame_sync[1], 5'h00, cnt_reg};
  wire [DATA_W-1:0] pos_word    = {7'h00, fgb_pos_reg, 7'h00, fga_pos_reg};

  always_comb begin
    unique case (REG_ADDR)
      OFS_CTRL:      rdata_next = DATA_W'(ctrl_reg);
      OFS_FGA_MODE:  rdata_next = DATA_W'(fga_mode_reg);
      OFS_FGA_LEVEL: rdata_next = DATA_W'(fga_level_reg);
      OFS_FGB_MODE:  rdata_next = DATA_W'(fgb_mode_reg);
      OFS_FGB_LEVEL: rdata_next = DATA_W'(fgb_level_reg);
      OFS_FG_POS:    rdata_next = pos_word;
      OFS_STATUS:    rdata_next = status_word;
      default:       rdata_next = '0;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST)         rdata_reg <= '0;
    else if (REG_RD) rdata_reg <= rdata_next;
    else             rdata_reg <= '0;
  end

  assign REG_RDATA = rdata_reg;

  // ========================================================================
  // Checks
  logic pol8_q;
  logic pol4_q;
  logic pol2_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pol8_q <= 1'b0;
      pol4_q <= 1'b0;
      pol2_q <= 1'b0;
    end else begin
      pol8_q <= pol8;
      pol4_q <= pol4;
      pol2_q <= pol2;
    end
  end

  chk_ctl_rate: assert property (@(posedge CORE_CLK) disable iff (RST || !master_reg) // R2
    ctl_tick |-> ##1 !ctl_tick [*8] ##8 ctl_tick)
    else $error("control stream bit period wrong");

  chk_frame_low: assert property (@(posedge CORE_CLK) disable iff (RST || !master_reg) // R5
    $fell(LOCAL_FRAME_N) |-> !LOCAL_FRAME_N [*4] ##1 LOCAL_FRAME_N)
    else $error("local frame pulse width wrong");

  chk_lrate_2m: assert property (@(posedge CORE_CLK)
    disable iff (RST || !master_reg || wr_ctrl) // R1
    LOCAL_BIT_STROBE && rate_sel == RATE_2M |-> ##8 LOCAL_BIT_STROBE)
    else $error("local bit period wrong at lowest rate");

  chk_c2_hiz: assert property (@(posedge CORE_CLK) disable iff (RST) // R4
    !c2_drv |=> !BACKPLANE_CLOCK_2M_OE)
    else $error("backplane 2M clock driven while not selected");

  chk_c4_dir: assert property (@(posedge CORE_CLK) disable iff (RST) // R14
    BACKPLANE_CLOCK_4M_OE == $past(master_reg))
    else $error("backplane 4M clock direction wrong");

  chk_frame_dir: assert property (@(posedge CORE_CLK) disable iff (RST) // R15
    !master_reg ##1 !master_reg |-> !BACKPLANE_FRAME_PULSE_N_OE)
    else $error("frame line driven in slave mode");

  chk_sec_dir: assert property (@(posedge CORE_CLK) disable iff (RST) // R13
    DPLL_REF_PULSE |-> !SECONDARY_8K_REFERENCE_OE && !$past(sec_drv))
    else $error("secondary reference used while driven");

  chk_local_clock_8m_toggle: assert property (@(posedge CORE_CLK) disable iff (RST) // R6
    master_reg && pol8 == pol8_q |=> LOCAL_CLOCK_8M != $past(LOCAL_CLOCK_8M))
    else $error("8M local clock failed to toggle");

  chk_local_clock_4m_match: assert property (@(posedge CORE_CLK) disable iff (RST) // R7
    LOCAL_CLOCK_4M == (BACKPLANE_CLOCK_4M_O ^ pol4_q))
    else $error("4M local clock differs from backplane clock");

  chk_local_clock_2m_match: assert property (@(posedge CORE_CLK) disable iff (RST) // R8
    LOCAL_CLOCK_2M == (BACKPLANE_CLOCK_2M_O ^ pol2_q))
    else $error("2M local clock differs from backplane clock");

  chk_fga_static: assert property (@(posedge CORE_CLK) disable iff (RST) // R11
    fga_mode_reg[1:0] == FG_STATIC |=> FRAME_GROUP_A_OUT[0] == $past(fga_level_reg[0]))
    else $error("group A static level wrong");

  chk_fgb_drive: assert property (@(posedge CORE_CLK) disable iff (RST) // R12
    fgb_mode_reg[1:0] == FG_DRIVE |=> FRAME_GROUP_B_OUT[0] == $past(STREAM_IN_DRIVE_EN[0]))
    else $error("group B drive enable wrong");

  chk_fg_pulse: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
    fga_mode_reg[1:0] == FG_PULSE && fga_pos_reg == FRAME_LOW_POS
      |=> FRAME_GROUP_A_OUT[0] == LOCAL_FRAME_N)
    else $error("group A pulse not aligned to frame");

  cov_master_frame: cover property (@(posedge CORE_CLK) disable iff (RST)
    master_reg && $fell(LOCAL_FRAME_N));

  cov_slave_align: cover property (@(posedge CORE_CLK) disable iff (RST)
    !master_reg && frame_fell);

  cov_fast_rate: cover property (@(posedge CORE_CLK) disable iff (RST)
    rate_sel == RATE_8M && LOCAL_BIT_STROBE ##2 LOCAL_BIT_STROBE);

endmodule : ltc_top

// File: tb/ltc_far_side.sv
`timescale 1ns/1ps
// ==========================================================================
// Connection memory and backplane timing source
module ltc_far_side (
  // Clock
  input  wire logic       clk,
  // Connection memory lookup
  input  wire logic [6:0] cm_addr,
  output logic            cm_bit,
  // Backplane lines as seen by a slave
  output logic            frame_n,
  output logic            local_clock_4m,
  output logic            sec
);
  logic [127:0] ctl_mem;
  logic [10:0]  t_reg = 11'h000;

  // Frame timebase of the bus owner
  always_ff @(posedge clk) begin
    t_reg <= t_reg + 11'h001;
  end

  // Control bit answered in the same cycle
  assign cm_bit  = ctl_mem[cm_addr];
  // Bus timing driven while the device only listens
  assign frame_n = (t_reg < 11'h004) ? 1'b0 : 1'b1;
  assign local_clock_4m    = t_reg[1];
  assign sec     = (t_reg[10:2] == 9'h100) ? 1'b0 : 1'b1;
endmodule : ltc_far_side

// File: tb/local_timing_control_outputs_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module local_timing_control_outputs_bench
  import ltc_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cmb, f_m, c4_m, s_m;
  logic [7:0]  addr = 8'h00, c;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  tx = 4'h0, rx = 4'h0, so, ri;
  logic [11:0] den_o = 12'h000, den_i = 12'h000, fga, fgb, lva, lvb;
  logic        f_o, f_oe, c4_o, c4_oe, c2_o, c2_oe, s_o, s_oe, dpll, l8, l4, l2, lf, stb, cso;
  logic        l8p, c4p;
  logic [6:0]  cma, pa;
  int          n_errors = 0, n_compared = 0, k, n, gap, lows, hits;
  wire         f_w  = f_oe ? f_o : f_m;
  wire         c4_w = c4_oe ? c4_o : c4_m;
  wire         s_w  = s_oe ? s_o : s_m;

  // Core clock, 100 ns period
  always #50 clk = ~clk;

  ltc_top dut_u (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .BACKPLANE_FRAME_PULSE_N_I(f_w),
    .BACKPLANE_FRAME_PULSE_N_O(f_o), .BACKPLANE_FRAME_PULSE_N_OE(f_oe),
    .BACKPLANE_CLOCK_4M_I(c4_w), .BACKPLANE_CLOCK_4M_O(c4_o), .BACKPLANE_CLOCK_4M_OE(c4_oe),
    .BACKPLANE_CLOCK_2M_O(c2_o), .BACKPLANE_CLOCK_2M_OE(c2_oe),
    .SECONDARY_8K_REFERENCE_I(s_w), .SECONDARY_8K_REFERENCE_O(s_o),
    .SECONDARY_8K_REFERENCE_OE(s_oe), .DPLL_REF_PULSE(dpll), .LOCAL_CLOCK_8M(l8),
    .LOCAL_CLOCK_4M(l4), .LOCAL_CLOCK_2M(l2), .LOCAL_FRAME_N(lf), .LOCAL_SERIAL_OUT(so),
    .LOCAL_SERIAL_IN(rx), .LOCAL_TX_BITS(tx), .LOCAL_RX_BITS(ri), .LOCAL_BIT_STROBE(stb),
    .CONTROL_STREAM_OUT(cso), .CM_SLOT_ADDR(cma), .CM_CTRL_BIT(cmb),
    .STREAM_OUT_DRIVE_EN(den_o), .STREAM_IN_DRIVE_EN(den_i), .FRAME_GROUP_A_OUT(fga),
    .FRAME_GROUP_B_OUT(fgb));

  ltc_far_side far_u (.clk(clk), .cm_addr(cma), .cm_bit(cmb), .frame_n(f_m), .local_clock_4m(c4_m),
    .sec(s_m));

  // Bit period in core cycles per rate code
  function automatic int per(input logic [1:0] r);
    return (r == RATE_4M) ? 4 : (r == RATE_8M) ? 2 : 8;
  endfunction : per

  // Expected frame group outputs
  function automatic logic [11:0] fg_exp(input logic [23:0] m, input logic [11:0] lv, de,
                                         input logic fr);
    for (int i = 0; i < 12; i++) begin
      case (m[2*i +: 2])
        FG_STATIC: fg_exp[i] = lv[i];
        FG_DRIVE:  fg_exp[i] = de[i];
        FG_PULSE:  fg_exp[i] = fr;
        default:   fg_exp[i] = 1'b0;
      endcase
    end
  endfunction : fg_exp

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    `CHK(nm, e, rdata)
  endtask : rd_chk

  // Reset pulse with idle levels checked while it is held
  task automatic do_reset(input int len);
    @(posedge clk);
    rst <= 1'b1;
    repeat (len) @(posedge clk);
    @(negedge clk);
    `CHK("reset levels", 16'hFFF8, {fga, lf, f_oe, c4_oe, c2_oe})
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
    rd_chk(OFS_FGA_LEVEL, 32'hFFF, "level reset");
    rd_chk(OFS_FG_POS, 32'h01FF01FF, "pos reset");
  endtask : do_reset

  // Count secondary reference pulses over one frame
  task automatic count_dpll(input int e);
    hits = 0;
    repeat (2048) @(negedge clk) hits += (dpll === 1'b1);
    `CHK("dpll pulses", e, hits)
  endtask : count_dpll

  initial begin
    void'($urandom(32'h734F));
    far_u.ctl_mem = {$urandom, $urandom, $urandom, $urandom};
    do_reset(16);
    rd_chk(8'h40, 32'h0, "unmapped");
    // Clock shapes, polarity, rates and serial transfer
    for (n = 0; n < 6; n++) begin
      c = 8'($urandom);
      c[CTRL_MASTER] = 1'b0;
      c[CTRL_RATE_LSB +: 2] = 2'(n % 3);
      wr_reg(OFS_CTRL, {24'h0, c});
      rx <= 4'($urandom);
      rd_chk(OFS_CTRL, {24'h0, c}, "ctrl");
      `CHK("c2 oe", c[CTRL_C2_DRV], c2_oe)
      `CHK("sec oe", c[CTRL_SEC_DRV], s_oe)
      {l8p, c4p} = {l8, c4_o};
      for (k = 0; k < 8; k++) begin
        @(negedge clk);
        `CHK("local_clock_8m", ~l8p, l8)
        if (c4_o !== c4p) `CHK("local_clock_8m phase", 1'b0, l8 ^ c[CTRL_POL8])
        `CHK("local_clock_4m", c4_o ^ c[CTRL_POL4], l4)
        `CHK("local_clock_2m", c2_o ^ c[CTRL_POL2], l2)
        {l8p, c4p} = {l8, c4_o};
      end
      @(posedge clk);
      tx <= 4'($urandom);
      @(negedge clk);
      for (k = 0; k < 20 && stb !== 1'b1; k++) @(negedge clk);
      `CHK("strobe seen", 1'b1, stb)
      @(negedge clk);
      `CHK("serial out", tx, so)
      `CHK("serial in", rx, ri)
      for (k = 1; k < 9 && stb !== 1'b1; k++) @(negedge clk);
      `CHK("strobe gap", per(c[4:3]), k)
    end
    // Frame groups, local frame and control stream over a frame
    {lva, lvb} = 24'($urandom);
    wr_reg(OFS_FGA_MODE, 32'h492492);
    wr_reg(OFS_FGA_LEVEL, {20'h0, lva});
    wr_reg(OFS_FGB_MODE, 32'hE49249);
    wr_reg(OFS_FGB_LEVEL, {20'h0, lvb});
    den_o <= 12'($urandom);
    den_i <= 12'($urandom);
    // Let the slave take the bus frame once before frame checks
    for (k = 0; k < 4096 && f_m !== 1'b0; k++) @(negedge clk);
    `CHK("frame seen", 1'b0, f_m)
    repeat (8) @(negedge clk);
    {lows, gap, pa} = {32'h0, 32'h0, cma};
    for (k = 0; k < 2048; k++) begin
      @(negedge clk);
      lows += (lf === 1'b0);
      gap++;
      `CHK("group a", fg_exp(24'h492492, lva, den_o, lf), fga)
      `CHK("group b", fg_exp(24'hE49249, lvb, den_i, lf), fgb)
      if (cma !== pa) begin
        `CHK("ctl bit", far_u.ctl_mem[7'(cma - 7'h01)], cso)
        if (k > 16) `CHK("ctl gap", 16, gap)
        {gap, pa} = {32'h0, cma};
      end
    end
    `CHK("frame lows", 4, lows)
    // Slave and master ownership of the backplane lines
    wr_reg(OFS_CTRL, 32'h0);
    count_dpll(1);
    wr_reg(OFS_CTRL, 32'h7);
    repeat (3) @(negedge clk);
    `CHK("master oe", 4'hF, {f_oe, c4_oe, s_oe, c2_oe})
    `CHK("sec carries frame", lf, s_o)
    count_dpll(0);
    do_reset(2);
    report_and_stop();
  end
endmodule : local_timing_control_outputs_bench
